// [src/rtc_port_pkg.sv]
// constants shared by the two ends of the rtc serial register port
package rtc_port_pkg;
   localparam logic [6:0] SLAVE_ADDR = 7'h68;
   localparam logic [7:0] AGING_OFFSET = 8'h10;
   localparam logic [7:0] TEMP_HIGH_OFFSET = 8'h11;
   localparam logic [7:0] TEMP_LOW_OFFSET = 8'h12;
   localparam logic [9:0] TEMP_RESET = 10'h000;
   localparam logic [7:0] AGING_RESET = 8'h00;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam int TEMP_LOW_POS = 6;
   // host apb registers
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TXDATA = 8'h08;
   localparam logic [7:0] REG_RXDATA = 8'h0c;
   localparam logic [7:0] REG_DIV = 8'h10;
   // ctrl command bits
   localparam int CMD_START_POS = 0;
   localparam int CMD_STOP_POS = 1;
   localparam int CMD_WRITE_POS = 2;
   localparam int CMD_READ_POS = 3;
   localparam int CMD_NACK_POS = 4;
   // link timing: 250 MHz clock, 400 kHz fastest bus
   localparam int CLK_MHZ = 250;
   localparam int LINK_KHZ = 400;
   localparam int QUARTER_CYCLES = (CLK_MHZ * 1000) / (LINK_KHZ * 4);
   localparam logic [15:0] DIV_RESET = 16'(QUARTER_CYCLES);
endpackage

// [src/rtc_link_if.sv]
// two-wire link joining the register port and its bus master
`timescale 1ns/100ps
interface rtc_link_if;
   logic scl_o;
   logic scl_oe_n;
   logic sda_m_o;
   logic sda_m_oe_n;
   logic sda_s_o;
   logic sda_s_oe_n;
   // open-drain wires, pulled high
   wire scl = scl_oe_n ? 1'b1 : scl_o;
   wire sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);
   modport master (output scl_o, output scl_oe_n, output sda_m_o,
      output sda_m_oe_n, input sda);
   modport slave (input scl, input sda, output sda_s_o,
      output sda_s_oe_n);
endinterface

// [src/rtc_port_slave.sv]
// serial slave port with aging offset and temperature result registers
//
// Implementation choice: register access over the two-wire link.
`timescale 1ns/100ps
module rtc_port_slave (
   // clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // link
   rtc_link_if.slave LINK,
   // temperature converter side
   input wire logic TEMP_VALID_I,
   input wire logic [9:0] TEMP_CODE_I,
   output logic CONV_START_O,
   // capacitance array side
   input wire logic [7:0] CAP_CODE_I,
   output logic [7:0] CAP_TRIM_O,
   output logic [7:0] AGING_O
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_RECV = 5'b00100,
      ST_SEND = 5'b01000,
      ST_ACK = 5'b10000
   } state_t;

   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic scl_d;
   logic sda_d;
   state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic rw;
   logic have_ptr;
   logic acking;
   logic master_ack;
   logic [7:0] pointer;
   logic [7:0] aging;
   logic [9:0] temp;
   logic conv_started;
   logic [7:0] rd_byte;

   // two flops before any logic looks at the pins
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         scl_sync <= 2'b11;
         sda_sync <= 2'b11;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], LINK.scl};
         sda_sync <= {sda_sync[0], LINK.sda};
         scl_d <= scl_sync[1];
         sda_d <= sda_sync[1];
      end
   end

   wire scl_rise = scl_sync[1] & ~scl_d;
   wire scl_fall = ~scl_sync[1] & scl_d;
   wire start_det = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
   wire stop_det = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

   always_comb begin
      unique case (pointer)
         rtc_port_pkg::AGING_OFFSET: rd_byte = aging;
         rtc_port_pkg::TEMP_HIGH_OFFSET: rd_byte = temp[9:2];
         rtc_port_pkg::TEMP_LOW_OFFSET:
            rd_byte = 8'(temp[1:0]) << rtc_port_pkg::TEMP_LOW_POS;
         default: rd_byte = 8'h00;
      endcase
   end

   // protocol engine; oversampling at 250 MHz covers 400 kHz
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         rw <= 1'b0;
         have_ptr <= 1'b0;
         acking <= 1'b0;
         master_ack <= 1'b0;
         pointer <= rtc_port_pkg::POINTER_RESET;
         aging <= rtc_port_pkg::AGING_RESET;
      end else if (start_det) begin
         state <= ST_ADDR;
         bit_cnt <= 4'h0;
         have_ptr <= 1'b0;
         acking <= 1'b0;
      end else if (stop_det) begin
         state <= ST_IDLE;
         acking <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               acking <= 1'b0;
            end
            ST_ADDR, ST_RECV: begin
               if (scl_rise) begin
                  shift <= {shift[6:0], sda_sync[1]};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  if (state == ST_ADDR) begin
                     if (shift[7:1] == rtc_port_pkg::SLAVE_ADDR) begin
                        rw <= shift[0];
                        acking <= 1'b1;
                        state <= ST_ACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else begin
                     acking <= 1'b1;
                     state <= ST_ACK;
                     if (!have_ptr) begin
                        pointer <= shift;
                        have_ptr <= 1'b1;
                     end else begin
                        if (pointer == rtc_port_pkg::AGING_OFFSET) begin
                           aging <= shift;
                        end
                        pointer <= pointer + 8'h01;
                     end
                  end
               end
            end
            ST_ACK: begin
               // acknowledge held low over the whole ninth clock
               if (scl_rise) begin
                  master_ack <= ~sda_sync[1];
               end else if (scl_fall) begin
                  acking <= 1'b0;
                  if (rw) begin
                     shift <= rd_byte;
                     pointer <= pointer + 8'h01;
                     state <= ST_SEND;
                  end else begin
                     state <= ST_RECV;
                  end
               end
            end
            ST_SEND: begin
               if (scl_fall) begin
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == 4'h8) begin
                     bit_cnt <= 4'h0;
                     if (master_ack) begin
                        shift <= rd_byte;
                        pointer <= pointer + 8'h01;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else if (bit_cnt != 4'h7) begin
                     shift <= {shift[6:0], 1'b0};
                  end
               end else if (scl_rise && bit_cnt == 4'h8) begin
                  master_ack <= ~sda_sync[1];
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // send: msb on line during bits 0..7, released for master ack
   wire send_low = (state == ST_SEND) && (bit_cnt != 4'h8) && !shift[7];

   // slave only drives data low, never the clock
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         LINK.sda_s_oe_n <= 1'b1;
      end else begin
         LINK.sda_s_oe_n <= ~(acking | send_low);
      end
   end
   assign LINK.sda_s_o = 1'b0;

   // temperature: zero at reset, then each new reading
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         temp <= rtc_port_pkg::TEMP_RESET;
         conv_started <= 1'b0;
         CONV_START_O <= 1'b0;
      end else begin
         CONV_START_O <= ~conv_started;
         conv_started <= 1'b1;
         if (TEMP_VALID_I) begin
            temp <= TEMP_CODE_I;
         end
      end
   end

   // aging code is signed and summed on each array update
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         CAP_TRIM_O <= 8'h00;
      end else if (TEMP_VALID_I) begin
         CAP_TRIM_O <= CAP_CODE_I + aging;
      end
   end
   assign AGING_O = aging;
endmodule // rtc_port_slave

// [src/rtc_port_master.sv]
// apb-controlled two-wire bus master for the register port
`timescale 1ns/100ps
module rtc_port_master (
   // clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // link
   rtc_link_if.master LINK
);
   typedef enum logic [3:0] {
      M_IDLE = 4'b0001,
      M_START = 4'b0010,
      M_BITS = 4'b0100,
      M_STOP = 4'b1000
   } mstate_t;

   logic [1:0] sda_sync;
   mstate_t state;
   logic [4:0] cmd;
   logic [7:0] txd;
   logic [7:0] rxd;
   logic [15:0] div;
   logic [15:0] cnt;
   logic [1:0] phase;
   logic [3:0] bit_cnt;
   logic [8:0] shift;
   logic got_ack;
   logic scl_low;
   logic sda_low;
   logic [31:0] rd_mux;
   wire busy = state != M_IDLE;
   // free bus: nothing pulled by us and data seen high on the wire
   wire bus_idle = !scl_low && !sda_low && sda_sync[1];
   wire wr = PSEL_I && PENABLE_I && PWRITE_I;

   assign PREADY_O = 1'b1;
   assign PSLVERR_O = 1'b0;

   always_comb begin
      unique case (PADDR_I)
         rtc_port_pkg::REG_STATUS: rd_mux = {30'h0, got_ack, busy};
         rtc_port_pkg::REG_RXDATA: rd_mux = {24'h0, rxd};
         rtc_port_pkg::REG_TXDATA: rd_mux = {24'h0, txd};
         rtc_port_pkg::REG_DIV: rd_mux = {16'h0, div};
         default: rd_mux = 32'h0;
      endcase
   end

   // read word captured in the setup cycle; zero-wait access then
   // returns a snapshot one cycle old
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         PRDATA_O <= 32'h0;
      end else if (PSEL_I && !PENABLE_I) begin
         PRDATA_O <= rd_mux;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         sda_sync <= 2'b11;
      end else begin
         sda_sync <= {sda_sync[0], LINK.sda};
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         txd <= 8'h00;
         div <= rtc_port_pkg::DIV_RESET;
      end else if (wr && PADDR_I == rtc_port_pkg::REG_TXDATA) begin
         txd <= PWDATA_I[7:0];
      end else if (wr && PADDR_I == rtc_port_pkg::REG_DIV && !busy) begin
         div <= (PWDATA_I[15:0] == 16'h0) ? 16'h1 : PWDATA_I[15:0];
      end
   end

   wire tick = cnt == 16'h0;

   // bus clock from divider; four phases per bit
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         state <= M_IDLE;
         cmd <= 5'h0;
         cnt <= 16'h0;
         phase <= 2'h0;
         bit_cnt <= 4'h0;
         shift <= 9'h1ff;
         got_ack <= 1'b0;
         rxd <= 8'h00;
         scl_low <= 1'b0;
         sda_low <= 1'b0;
      end else if (state == M_IDLE) begin
         cnt <= div - 16'h1;
         phase <= 2'h0;
         if (wr && PADDR_I == rtc_port_pkg::REG_CTRL) begin
            cmd <= PWDATA_I[4:0];
            bit_cnt <= 4'h0;
            if (PWDATA_I[rtc_port_pkg::CMD_START_POS]) begin
               // fresh start needs a free bus; own clock allows repeated
               if (bus_idle || scl_low) begin
                  state <= M_START;
               end
            end else if (PWDATA_I[rtc_port_pkg::CMD_WRITE_POS]) begin
               shift <= {txd, 1'b1};
               state <= M_BITS;
            end else if (PWDATA_I[rtc_port_pkg::CMD_READ_POS]) begin
               // ack all but the last byte
               shift <= {8'hff, PWDATA_I[rtc_port_pkg::CMD_NACK_POS]};
               state <= M_BITS;
            end else if (PWDATA_I[rtc_port_pkg::CMD_STOP_POS]) begin
               state <= M_STOP;
            end
         end
      end else if (!tick) begin
         cnt <= cnt - 16'h1;
      end else begin
         cnt <= div - 16'h1;
         phase <= phase + 2'h1;
         unique case (state)
            M_START: begin
               // start or repeated start: release data, raise clock, pull data
               case (phase)
                  2'h0: sda_low <= 1'b0;
                  2'h1: scl_low <= 1'b0;
                  2'h2: sda_low <= 1'b1;
                  default: begin
                     scl_low <= 1'b1;
                     state <= cmd[rtc_port_pkg::CMD_WRITE_POS] ?
                        M_BITS : M_IDLE;
                     shift <= {txd, 1'b1};
                  end
               endcase
            end
            M_BITS: begin
               case (phase)
                  2'h0: sda_low <= ~shift[8];
                  2'h1: scl_low <= 1'b0;
                  2'h2: begin
                     shift <= {shift[7:0], sda_sync[1]};
                     if (bit_cnt == 4'h8) begin
                        got_ack <= ~sda_sync[1];
                     end
                  end
                  default: begin
                     scl_low <= 1'b1;
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt == 4'h8) begin
                        sda_low <= 1'b0;
                        rxd <= shift[8:1];
                        state <= cmd[rtc_port_pkg::CMD_STOP_POS] ?
                           M_STOP : M_IDLE;
                     end
                  end
               endcase
            end
            M_STOP: begin
               case (phase)
                  2'h0: sda_low <= 1'b1;
                  2'h1: scl_low <= 1'b0;
                  2'h2: sda_low <= 1'b0;
                  default: state <= M_IDLE;
               endcase
            end
            default: state <= M_IDLE;
         endcase
      end
   end

   // master owns the clock and all conditions
   assign LINK.scl_o = 1'b0;
   assign LINK.scl_oe_n = ~scl_low;
   assign LINK.sda_m_o = 1'b0;
   assign LINK.sda_m_oe_n = ~sda_low;
endmodule // rtc_port_master

// [testbench/rtc_port_sva.sv]
// concurrent checks on the two-wire link between master and register port
`timescale 1ns/100ps
module rtc_port_sva (
   // clock and reset
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   // line drivers
   input wire logic scl_o,
   input wire logic scl_oe_n,
   input wire logic sda_m_o,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_o,
   input wire logic sda_s_oe_n,
   // resolved wires
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   sequence start_seen;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stop_seen;
      scl && $past(scl) && $rose(sda);
   endsequence
   sequence ack_at_rise;
      $rose(scl) && !sda_s_oe_n;
   endsequence

   AST_RESET_RELEASE: assert property (disable iff (1'b0)
      SYS_RST_I && $past(SYS_RST_I) |-> scl_oe_n && sda_m_oe_n && sda_s_oe_n)
      else $error("a line is pulled low during reset");
   AST_SLAVE_OPEN_DRAIN: assert property (
      !sda_s_oe_n |-> sda_s_o == 1'b0 && !sda)
      else $error("slave enabled without pulling data low");
   AST_MASTER_OPEN_DRAIN: assert property (
      !scl_oe_n |-> scl_o == 1'b0 && !scl)
      else $error("master enabled without pulling clock low");
   AST_SLAVE_CHANGES_LOW: assert property (
      $changed(sda_s_oe_n) |-> !scl)
      else $error("slave data enable moved while clock high");
   AST_ACK_STABLE: assert property (
      ack_at_rise |-> !sda_s_oe_n [*8])
      else $error("slave low level not held through clock high");
   AST_START_RELEASED: assert property (
      start_seen |-> sda_s_oe_n [*8])
      else $error("slave drives data right after start");
   AST_STOP_RELEASED: assert property (
      stop_seen |-> sda_s_oe_n [*8])
      else $error("slave drives data after stop");
   AST_SCL_HIGH_MIN: assert property (
      $rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   COV_START: cover property (start_seen);
endmodule // rtc_port_sva

// [testbench/tb_rtc_i2c_slave_register_port.sv]
// self-checking bench joining the bus master and the register port
`timescale 1ns/100ps
module tb_rtc_i2c_slave_register_port;
   typedef struct packed {logic [31:0] mask; logic [31:0] value;} note_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic temp_valid = 1'b0;
   logic [9:0] temp_code = 10'h000;
   logic [7:0] cap_code = 8'h00;
   logic conv_start;
   logic [7:0] cap_trim;
   logic [7:0] aging;
   logic watch = 1'b0;
   logic [7:0] exp_addr = 8'h00;
   logic [7:0] sh = 8'h00;
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic [31:0] q;
   logic [7:0] age;
   logic [7:0] cap;
   logic [7:0] tcur_h;
   logic [7:0] tcur_l;
   logic [9:0] tcode;
   note_t exp_q[$];
   int nbit = 9;
   int npulse = 0;
   int n_errors = 0;
   int compares = 0;

   rtc_link_if link ();
   rtc_port_master u_rtc_port_master (.CLK_I(clk), .SYS_RST_I(rst),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK(link));
   rtc_port_slave u_rtc_port_slave (.CLK_I(clk), .SYS_RST_I(rst),
      .LINK(link), .TEMP_VALID_I(temp_valid), .TEMP_CODE_I(temp_code),
      .CONV_START_O(conv_start), .CAP_CODE_I(cap_code),
      .CAP_TRIM_O(cap_trim), .AGING_O(aging));
   rtc_port_sva u_rtc_port_sva (.CLK_I(clk), .SYS_RST_I(rst),
      .scl_o(link.scl_o), .scl_oe_n(link.scl_oe_n),
      .sda_m_o(link.sda_m_o), .sda_m_oe_n(link.sda_m_oe_n),
      .sda_s_o(link.sda_s_o), .sda_s_oe_n(link.sda_s_oe_n),
      .scl(link.scl), .sda(link.sda));

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("mismatches %0d of %0d compares", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic compare_rd(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         n_errors++;
         $display("MISMATCH t=%0t read=%h expected=%h", $time, got, want);
      end
   endtask

   task automatic compare_port(input logic [7:0] got, input logic [7:0] want);
      compares++;
      if (got !== want) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, want);
      end
   endtask

   // entered just after a rising edge; leaves an idle cycle behind
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic ck);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      watch <= ck;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      watch <= 1'b0;
      @(posedge clk);
   endtask

   task automatic cmd(input logic st, input logic sp, input logic w,
      input logic r, input logic nk);
      logic [31:0] c;
      c = 32'h0;
      c[rtc_port_pkg::CMD_START_POS] = st;
      c[rtc_port_pkg::CMD_STOP_POS] = sp;
      c[rtc_port_pkg::CMD_WRITE_POS] = w;
      c[rtc_port_pkg::CMD_READ_POS] = r;
      c[rtc_port_pkg::CMD_NACK_POS] = nk;
      apb(1'b1, rtc_port_pkg::REG_CTRL, c, 1'b0);
      q = 32'h1;
      while (q[0] !== 1'b0) apb(1'b0, rtc_port_pkg::REG_STATUS, 32'h0, 1'b0);
   endtask

   task automatic wr_byte(input logic [7:0] b, input logic st,
      input logic ack);
      note_t n;
      apb(1'b1, rtc_port_pkg::REG_TXDATA, {24'h0, b}, 1'b0);
      if (st) exp_addr = b;
      cmd(st, 1'b0, 1'b1, 1'b0, 1'b0);
      n.mask = 32'h2;
      n.value = {30'h0, ack, 1'b0};
      exp_q.push_back(n);
      apb(1'b0, rtc_port_pkg::REG_STATUS, 32'h0, 1'b1);
   endtask

   task automatic rd_byte(input logic [7:0] e, input logic last);
      note_t n;
      cmd(1'b0, last, 1'b0, 1'b1, last);
      n.mask = 32'hff;
      n.value = {24'h0, e};
      exp_q.push_back(n);
      apb(1'b0, rtc_port_pkg::REG_RXDATA, 32'h0, 1'b1);
   endtask

   always @(posedge clk) begin
      note_t n;
      if (conv_start === 1'b1) npulse++;
      if (watch && psel && penable && pready === 1'b1 && !pwrite) begin
         n = exp_q.pop_front();
         compare_rd(prdata & n.mask, n.value);
         compare_rd({31'h0, pslverr}, 32'h0);
      end
   end

   // address byte as it crosses the wire, sampled at clock rises
   always @(posedge clk) begin
      scl_q <= link.scl;
      sda_q <= link.sda;
      if (scl_q && link.scl && sda_q && !link.sda) begin
         nbit = 0;
      end else if (!scl_q && link.scl && nbit < 8) begin
         sh = {sh[6:0], link.sda};
         nbit++;
         if (nbit == 8) compare_port(sh, exp_addr);
      end
   end

   initial begin
      #320000;
      n_errors++;
      report_and_stop();
   end

   initial begin
      void'($urandom(32'haa7784be));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      compare_port(8'(npulse), 8'h01);
      // quarter bit shortened to keep the run brief
      apb(1'b1, rtc_port_pkg::REG_DIV, 32'h28, 1'b0);
      tcur_h = rtc_port_pkg::TEMP_RESET[9:2];
      tcur_l = {rtc_port_pkg::TEMP_RESET[1:0], 6'h00};
      for (int it = 0; it < 2; it++) begin
         age = 8'($urandom);
         tcode = 10'($urandom);
         cap = 8'($urandom);
         wr_byte(8'hd0, 1'b1, 1'b1);
         wr_byte(rtc_port_pkg::AGING_OFFSET, 1'b0, 1'b1);
         wr_byte(age, 1'b0, 1'b1);
         wr_byte(8'h55, 1'b0, 1'b1);
         wr_byte(8'h66, 1'b0, 1'b1);
         cmd(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
         compare_port(aging, age);
         wr_byte(8'hd0, 1'b1, 1'b1);
         wr_byte(rtc_port_pkg::TEMP_HIGH_OFFSET, 1'b0, 1'b1);
         wr_byte(8'hd1, 1'b1, 1'b1);
         rd_byte(tcur_h, 1'b0);
         rd_byte(tcur_l, 1'b1);
         temp_code <= tcode;
         cap_code <= cap;
         temp_valid <= 1'b1;
         @(posedge clk);
         temp_valid <= 1'b0;
         repeat (2) @(posedge clk);
         compare_port(cap_trim, cap + age);
         tcur_h = tcode[9:2];
         tcur_l = {tcode[1:0], 6'h00};
         wr_byte(8'hd0, 1'b1, 1'b1);
         wr_byte(rtc_port_pkg::AGING_OFFSET, 1'b0, 1'b1);
         wr_byte(8'hd1, 1'b1, 1'b1);
         rd_byte(age, 1'b0);
         rd_byte(tcur_h, 1'b0);
         rd_byte(tcur_l, 1'b1);
         wr_byte(8'ha0, 1'b1, 1'b0);
         wr_byte(rtc_port_pkg::AGING_OFFSET, 1'b0, 1'b0);
         wr_byte(~age, 1'b0, 1'b0);
         cmd(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
         compare_port(aging, age);
      end
      // pointer left past the last byte read, untouched by the stranger
      wr_byte(8'hd1, 1'b1, 1'b1);
      rd_byte(8'h00, 1'b1);
      report_and_stop();
   end
endmodule // tb_rtc_i2c_slave_register_port
